/* bfl_backlight_flash_regs.v */
`timescale 1ns/1ns
`include "bfl_defs.vh"

// Behaviour
// R1: config one bit 3 inverts PWM input
// R2: config two bit 7 picks boost frequency
// R3: bits 6-3 set fixed brightness ramp time
// R4: config two bit 2 picks PWM sample rate
// R5: bits 1-0 set duty change hysteresis
// R6: low register bits 2-0 are code lsbs
// R7: high register holds upper eight code bits
// R8: code zero turns backlight off
// R9: linear curve: offset plus slope times code
// R10: exponential curve: 50 uA times base^code
// R11: torch current bits 7-4, 25 mA steps
// R12: flash current bits 3-0, 100 mA steps
// R13: registers load documented reset values
// R14: config one bit 4 selects linear/exponential
// R15: PWM enabled scales target by duty
// R16: reserved bits read zero, writes ignored
module bfl_backlight_flash_regs #(
  parameter CYC_PER_US = `BFL_CLK_MHZ
) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // serial control bus, open drain data
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // pwm input
  input wire pwm_i,
  input wire pwm_enable_i,
  // backlight controls
  output wire boost_switch_freq_select_o,
  output wire brightness_curve_select_o,
  output reg backlight_on_o,
  output reg ramp_busy_o,
  output reg [10:0] ramp_code_o,
  output reg [19:0] led_current_o,
  output reg [11:0] pwm_duty_o,
  // flash controls
  output wire [3:0] torch_current_level_o,
  output wire [3:0] flash_current_level_o
);

  localparam integer FAST_DIV_RAW = CYC_PER_US / `BFL_FAST_SAMPLE_MHZ;
  localparam integer SLOW_DIV_RAW = CYC_PER_US / `BFL_SLOW_SAMPLE_MHZ;
  localparam [7:0] FAST_DIV = (FAST_DIV_RAW < 1) ? 8'h01 : FAST_DIV_RAW[7:0];
  localparam [7:0] SLOW_DIV = (SLOW_DIV_RAW < 1) ? 8'h01 : SLOW_DIV_RAW[7:0];

  function [23:0] ramp_us;
    input [3:0] code;
    begin
      case (code)
        4'h0: ramp_us = `BFL_RAMP_US_0;
        4'h1: ramp_us = `BFL_RAMP_US_1;
        4'h2: ramp_us = `BFL_RAMP_US_2;
        4'h3: ramp_us = `BFL_RAMP_US_3;
        4'h4: ramp_us = `BFL_RAMP_US_4;
        4'h5: ramp_us = `BFL_RAMP_US_5;
        4'h6: ramp_us = `BFL_RAMP_US_6;
        4'h7: ramp_us = `BFL_RAMP_US_7;
        4'h8: ramp_us = `BFL_RAMP_US_8;
        4'h9: ramp_us = `BFL_RAMP_US_9;
        4'ha: ramp_us = `BFL_RAMP_US_10;
        4'hb: ramp_us = `BFL_RAMP_US_11;
        4'hc: ramp_us = `BFL_RAMP_US_12;
        4'hd: ramp_us = `BFL_RAMP_US_13;
        4'he: ramp_us = `BFL_RAMP_US_14;
        default: ramp_us = `BFL_RAMP_US_15;
      endcase
    end
  endfunction

  function [11:0] hyst_lsbs;
    input [1:0] code;
    begin
      case (code)
        2'h0: hyst_lsbs = `BFL_HYST_0;
        2'h1: hyst_lsbs = `BFL_HYST_1;
        2'h2: hyst_lsbs = `BFL_HYST_2;
        default: hyst_lsbs = `BFL_HYST_3;
      endcase
    end
  endfunction

  // one-hot register select from the bus pointer
  function [4:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `BFL_REG_CFG_ONE: reg_sel = 5'h01;
        `BFL_REG_CFG_TWO: reg_sel = 5'h02;
        `BFL_REG_BRT_LOW: reg_sel = 5'h04;
        `BFL_REG_BRT_HIGH: reg_sel = 5'h08;
        `BFL_REG_FT_CUR: reg_sel = 5'h10;
        default: reg_sel = 5'h00;
      endcase
    end
  endfunction

  // reset release through two flops
  reg rst_q1;
  reg rst_n;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  wire wr_en;
  wire [7:0] reg_addr;
  wire [7:0] wdata;
  reg [7:0] rdata;

  bfl_serial_slave u_slave (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_en_o(wr_en),
    .addr_o(reg_addr),
    .wdata_o(wdata),
    .rdata_i(rdata)
  );

  // register file
  reg [7:0] backlight_config_one;
  reg [7:0] backlight_config_two;
  reg [7:0] brightness_code_low_reg;
  reg [7:0] brightness_code_high_reg;
  reg [7:0] flash_torch_current;
  wire [4:0] addr_sel = reg_sel(reg_addr);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      backlight_config_one <= `BFL_RST_CFG_ONE; // R13
      backlight_config_two <= `BFL_RST_CFG_TWO; // R13
      brightness_code_low_reg <= `BFL_RST_BRT_LOW; // R13
      brightness_code_high_reg <= `BFL_RST_BRT_HIGH; // R13
      flash_torch_current <= `BFL_RST_FT_CUR; // R13
    end else if (wr_en) begin
      // unmapped offsets are acked by the bus side and dropped here
      if (addr_sel[0]) begin
        backlight_config_one <= wdata & `BFL_MASK_CFG_ONE; // R16
      end
      if (addr_sel[1]) begin
        backlight_config_two <= wdata;
      end
      if (addr_sel[2]) begin
        brightness_code_low_reg <= wdata & `BFL_MASK_BRT_LOW; // R16
      end
      if (addr_sel[3]) begin
        brightness_code_high_reg <= wdata;
      end
      if (addr_sel[4]) begin
        flash_torch_current <= wdata;
      end
    end
  end

  // unmapped offsets read zero, so nothing outside the map leaks out
  always @* begin
    rdata = 8'h00; // R16
    if (addr_sel[0]) begin
      rdata = backlight_config_one;
    end
    if (addr_sel[1]) begin
      rdata = backlight_config_two;
    end
    if (addr_sel[2]) begin
      rdata = brightness_code_low_reg;
    end
    if (addr_sel[3]) begin
      rdata = brightness_code_high_reg;
    end
    if (addr_sel[4]) begin
      rdata = flash_torch_current;
    end
  end

  // field decode
  wire pwm_polarity = backlight_config_one[`BFL_POL_BIT];
  wire brightness_curve_select = backlight_config_one[`BFL_CURVE_BIT];
  wire [3:0] brightness_ramp_time = backlight_config_two[`BFL_RAMP_HI:`BFL_RAMP_LO];
  wire pwm_sample_rate_select = backlight_config_two[`BFL_RATE_BIT];
  wire [1:0] pwm_duty_hysteresis = backlight_config_two[`BFL_HYST_HI:`BFL_HYST_LO];
  wire [2:0] brightness_code_low = brightness_code_low_reg[`BFL_BRT_LOW_HI:0]; // R6
  wire [7:0] brightness_code_high = brightness_code_high_reg; // R7
  wire [10:0] brightness_code = {brightness_code_high, brightness_code_low}; // R6 R7

  assign boost_switch_freq_select_o = backlight_config_two[`BFL_FREQ_BIT]; // R2
  assign brightness_curve_select_o = brightness_curve_select; // R14
  assign torch_current_level_o = flash_torch_current[`BFL_TORCH_HI:`BFL_TORCH_LO]; // R11
  assign flash_current_level_o = flash_torch_current[`BFL_FLASH_HI:`BFL_FLASH_LO]; // R12

  // pwm sampling enable; rounds down when the clock is not a multiple
  reg [7:0] sample_div;
  reg sample_en;
  wire [7:0] div_last = (pwm_sample_rate_select ? FAST_DIV : SLOW_DIV) - 8'h01; // R4
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sample_div <= 8'h00;
      sample_en <= 1'b0;
    end else if (sample_div >= div_last) begin
      sample_div <= 8'h00;
      sample_en <= 1'b1;
    end else begin
      sample_div <= sample_div + 8'h01;
      sample_en <= 1'b0;
    end
  end

  // duty over a fixed window of samples, avoids a divider
  wire pwm_active = pwm_i ^ pwm_polarity; // R1
  reg [11:0] win_cnt;
  reg [11:0] high_cnt;
  wire [11:0] duty_new = high_cnt + {11'h000, pwm_active};
  wire [11:0] duty_diff = (duty_new > pwm_duty_o) ? duty_new - pwm_duty_o
                                                  : pwm_duty_o - duty_new;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= 12'h000;
      high_cnt <= 12'h000;
      pwm_duty_o <= `BFL_DUTY_FULL;
    end else if (!pwm_enable_i) begin
      win_cnt <= 12'h000;
      high_cnt <= 12'h000;
    end else if (sample_en) begin
      if (win_cnt == `BFL_DUTY_WIN_LAST) begin
        win_cnt <= 12'h000;
        high_cnt <= 12'h000;
        if (duty_diff >= hyst_lsbs(pwm_duty_hysteresis)) begin // R5
          pwm_duty_o <= duty_new;
        end
      end else begin
        win_cnt <= win_cnt + 12'h001;
        high_cnt <= duty_new;
      end
    end
  end

  // ramp target, duty full scale is 2^11
  wire [22:0] scaled = brightness_code * pwm_duty_o;
  wire [10:0] target = pwm_enable_i ? scaled[21:11] : brightness_code; // R15

  // fixed-duration ramp: bresenham spreads |delta| steps over the time
  wire [31:0] ramp_cycles = ramp_us(brightness_ramp_time) * CYC_PER_US; // R3
  reg [10:0] last_target;
  reg [10:0] delta;
  reg [31:0] acc;
  wire [31:0] acc_sum = acc + {21'h00_0000, delta};
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      last_target <= 11'h7ff;
      delta <= 11'h000;
      acc <= 32'h0000_0000;
      ramp_code_o <= 11'h7ff;
      ramp_busy_o <= 1'b0;
    end else if (target != last_target) begin
      // a new code restarts the full ramp time from the present level
      last_target <= target;
      delta <= (target > ramp_code_o) ? target - ramp_code_o : ramp_code_o - target;
      acc <= 32'h0000_0000;
      ramp_busy_o <= 1'b1;
    end else if (ramp_code_o != last_target) begin
      if (ramp_cycles == 32'h0000_0000) begin
        ramp_code_o <= last_target; // R3
      end else if (acc_sum >= ramp_cycles) begin
        acc <= acc_sum - ramp_cycles; // R3
        if (last_target > ramp_code_o) begin
          ramp_code_o <= ramp_code_o + 11'h001;
        end else begin
          ramp_code_o <= ramp_code_o - 11'h001;
        end
      end else begin
        acc <= acc_sum;
      end
    end else begin
      ramp_busy_o <= 1'b0;
    end
  end

  // code to current, units of 1/16 uA; exponential uses 2^x with linear fraction
  wire [19:0] lin_cur = `BFL_LIN_OFFSET + `BFL_LIN_SLOPE * ramp_code_o; // R9
  wire [19:0] exp_x = `BFL_EXP_K * ramp_code_o;
  wire [26:0] exp_m = `BFL_EXP_BASE * {1'b1, exp_x[15:0]};
  wire [19:0] exp_cur = {9'h000, exp_m[26:16]} << exp_x[19:16]; // R10
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      led_current_o <= 20'h0_0000;
      backlight_on_o <= 1'b0;
    end else if (ramp_code_o == 11'h000) begin
      led_current_o <= 20'h0_0000; // R8
      backlight_on_o <= 1'b0; // R8
    end else begin
      led_current_o <= brightness_curve_select ? lin_cur : exp_cur; // R14
      backlight_on_o <= 1'b1;
    end
  end

endmodule // bfl_backlight_flash_regs

/* bfl_defs.vh */
`ifndef BFL_DEFS_VH
`define BFL_DEFS_VH

// serial control bus
`define BFL_DEV_ADDR 7'h11
`define BFL_BYTE_BITS 4'h8

// register offsets
`define BFL_REG_CFG_ONE 8'h02
`define BFL_REG_CFG_TWO 8'h03
`define BFL_REG_BRT_LOW 8'h04
`define BFL_REG_BRT_HIGH 8'h05
`define BFL_REG_FT_CUR 8'h06

// reset values
`define BFL_RST_CFG_ONE 8'h30
`define BFL_RST_CFG_TWO 8'h0d
`define BFL_RST_BRT_LOW 8'h07
`define BFL_RST_BRT_HIGH 8'hff
`define BFL_RST_FT_CUR 8'h3e

// writable masks, reserved bits read zero
`define BFL_MASK_CFG_ONE 8'hf8
`define BFL_MASK_BRT_LOW 8'h07

// field positions
`define BFL_POL_BIT 3
`define BFL_CURVE_BIT 4
`define BFL_FREQ_BIT 7
`define BFL_RAMP_HI 6
`define BFL_RAMP_LO 3
`define BFL_RATE_BIT 2
`define BFL_HYST_HI 1
`define BFL_HYST_LO 0
`define BFL_BRT_LOW_HI 2
`define BFL_TORCH_HI 7
`define BFL_TORCH_LO 4
`define BFL_FLASH_HI 3
`define BFL_FLASH_LO 0

// timing
`define BFL_CLK_MHZ 50
`define BFL_FAST_SAMPLE_MHZ 4
`define BFL_SLOW_SAMPLE_MHZ 1
`define BFL_DUTY_WIN_LAST 12'h7ff
`define BFL_DUTY_FULL 12'h800

// ramp durations in microseconds, by code
`define BFL_RAMP_US_0 24'h00_0000
`define BFL_RAMP_US_1 24'h00_01f4
`define BFL_RAMP_US_2 24'h00_02ee
`define BFL_RAMP_US_3 24'h00_03e8
`define BFL_RAMP_US_4 24'h00_07d0
`define BFL_RAMP_US_5 24'h00_1388
`define BFL_RAMP_US_6 24'h00_2710
`define BFL_RAMP_US_7 24'h00_4e20
`define BFL_RAMP_US_8 24'h00_c350
`define BFL_RAMP_US_9 24'h01_86a0
`define BFL_RAMP_US_10 24'h03_d090
`define BFL_RAMP_US_11 24'h0c_3500
`define BFL_RAMP_US_12 24'h0f_4240
`define BFL_RAMP_US_13 24'h1e_8480
`define BFL_RAMP_US_14 24'h3d_0900
`define BFL_RAMP_US_15 24'h7a_1200

// hysteresis thresholds in duty lsbs
`define BFL_HYST_0 12'h001
`define BFL_HYST_1 12'h002
`define BFL_HYST_2 12'h004
`define BFL_HYST_3 12'h006

// current mapping, units of 1/16 uA
`define BFL_LIN_OFFSET 20'h0_025d
`define BFL_LIN_SLOPE 9'h0c3
`define BFL_EXP_BASE 10'h320
`define BFL_EXP_K 9'h11f

`endif

/* bfl_serial_slave.v */
`timescale 1ns/1ns
`include "bfl_defs.vh"

module bfl_serial_slave (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // bus pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe_o,
  // register port
  output reg wr_en_o,
  output reg [7:0] addr_o,
  output reg [7:0] wdata_o,
  input wire [7:0] rdata_i
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_REG = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_ACK = 3'h4;
  localparam ST_RD = 3'h5;
  localparam ST_RACK = 3'h6;

  reg scl_q;
  reg sda_q;
  reg [2:0] state;
  reg [2:0] after_ack;
  reg [3:0] cnt;
  reg [7:0] shreg;
  reg [7:0] txsr;
  reg master_ack;

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_seen = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_seen = scl_i & scl_q & ~sda_q & sda_i;

  // open drain: only ever pulls low
  assign sda_o = 1'b0;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      txsr <= 8'h00;
      master_ack <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_en_o <= 1'b0;
      addr_o <= 8'h00;
      wdata_o <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_en_o <= 1'b0;
      if (start_seen) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_REG, ST_WR: begin
            if (scl_rise && cnt != `BFL_BYTE_BITS) begin
              shreg <= {shreg[6:0], sda_i};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == `BFL_BYTE_BITS) begin
              state <= ST_ACK;
              sda_oe_o <= 1'b1;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == `BFL_DEV_ADDR) begin
                  after_ack <= shreg[0] ? ST_RD : ST_REG;
                end else begin
                  // not our address: stay off the line until next start
                  state <= ST_IDLE;
                  sda_oe_o <= 1'b0;
                end
              end else if (state == ST_REG) begin
                addr_o <= shreg;
                after_ack <= ST_WR;
              end else begin
                wdata_o <= shreg;
                wr_en_o <= 1'b1;
                after_ack <= ST_WR;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              sda_oe_o <= 1'b0;
              state <= after_ack;
              if (after_ack == ST_RD) begin
                txsr <= {rdata_i[6:0], 1'b0};
                sda_oe_o <= ~rdata_i[7];
                cnt <= 4'h1;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (cnt == `BFL_BYTE_BITS) begin
                sda_oe_o <= 1'b0;
                state <= ST_RACK;
                addr_o <= addr_o + 8'h01;
              end else begin
                sda_oe_o <= ~txsr[7];
                txsr <= {txsr[6:0], 1'b0};
                cnt <= cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_i;
            end else if (scl_fall) begin
              if (master_ack) begin
                state <= ST_RD;
                txsr <= {rdata_i[6:0], 1'b0};
                sda_oe_o <= ~rdata_i[7];
                cnt <= 4'h1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
        // auto increment after each stored data byte
        if (wr_en_o) begin
          addr_o <= addr_o + 8'h01;
        end
      end
    end
  end

endmodule // bfl_serial_slave

/* bfl_regs_props.sv */
`timescale 1ns/1ns
module bfl_regs_props (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // watched ports
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire boost_switch_freq_select_o,
  input wire brightness_curve_select_o,
  input wire backlight_on_o,
  input wire [10:0] ramp_code_o,
  input wire [19:0] led_current_o,
  input wire [11:0] pwm_duty_o,
  input wire [3:0] torch_current_level_o,
  input wire [3:0] flash_current_level_o
);
  // outputs lag the two-flop reset release
  reg [2:0] up_cnt;
  wire up = up_cnt == 3'h4;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) up_cnt <= 3'h0;
    else if (!up) up_cnt <= up_cnt + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_lit;
    up && ramp_code_o != 11'h000;
  endsequence
  sequence s_lin;
    s_lit ##0 brightness_curve_select_o;
  endsequence
  sequence s_exp;
    s_lit ##0 !brightness_curve_select_o;
  endsequence
  a_reset_vals: assert property ($rose(rstn_i) |-> {boost_switch_freq_select_o,
    brightness_curve_select_o, torch_current_level_o, flash_current_level_o} == 10'h13e)
    else $error("outputs not at reset values");
  a_lit_code: assert property (s_lit |=> backlight_on_o)
    else $error("backlight off with nonzero code");
  a_dark_zero: assert property (up && ramp_code_o == 11'h000 |=>
    !backlight_on_o && led_current_o == 20'h0_0000) else $error("zero code not dark");
  a_linear_map: assert property (s_lin |=>
    led_current_o == 20'h0_025d + 20'h0_00c3 * {9'h000, $past(ramp_code_o)})
    else $error("linear current wrong");
  a_exp_floor: assert property (s_exp |=> led_current_o >= 20'h0_0320)
    else $error("exponential current below base");
  a_duty_bound: assert property (up |-> pwm_duty_o <= 12'h800)
    else $error("duty above full scale");
  a_level_load: assert property ($changed(torch_current_level_o) ||
    $changed(flash_current_level_o) || $changed(boost_switch_freq_select_o) |-> !scl_i)
    else $error("level changed outside a bus write");
  a_curve_load: assert property ($changed(brightness_curve_select_o) |-> !scl_i)
    else $error("curve changed outside a bus write");
  a_ack_low_phase: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed with serial clock high");
  a_drive_zero: assert property (sda_o == 1'b0)
    else $error("open drain drive value not zero");
endmodule // bfl_regs_props

bind bfl_backlight_flash_regs bfl_regs_props u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .boost_switch_freq_select_o(boost_switch_freq_select_o),
  .brightness_curve_select_o(brightness_curve_select_o),
  .backlight_on_o(backlight_on_o), .ramp_code_o(ramp_code_o),
  .led_current_o(led_current_o), .pwm_duty_o(pwm_duty_o),
  .torch_current_level_o(torch_current_level_o),
  .flash_current_level_o(flash_current_level_o)
);

/* bfl_host_model.sv */
`timescale 1ns/1ns
`include "bfl_defs.vh"
module bfl_host_model (
  // clock
  input wire clk_i,
  // bus pins, data is open drain
  input wire sda_i,
  output logic scl_o,
  output logic sda_low_o,
  // read results
  output logic rd_valid_o,
  output logic [7:0] rd_data_o
);
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // four clocks per phase, above the three-clock minimum
  task automatic pulse(output logic s);
    tick(3);
    scl_o = 1'b1;
    tick(4);
    s = sda_i;
    scl_o = 1'b0;
    tick(1);
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_low_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_low_o = 1'b0;
    tick(4);
  endtask
  task automatic put(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = ~b[i];
      pulse(s);
    end
    sda_low_o = 1'b0;
    pulse(s);
    if (s) nacks++;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    sda_low_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_low_o = ~last;
    pulse(s);
    sda_low_o = 1'b0;
    rd_data_o = b;
    rd_valid_o = 1'b1;
    tick(1);
    rd_valid_o = 1'b0;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d);
    start();
    put({dev, 1'b0});
    put(ra);
    put(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] ra, input int n);
    logic [7:0] b;
    start();
    put({`BFL_DEV_ADDR, 1'b0});
    put(ra);
    start();
    put({`BFL_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) get(i == n - 1, b);
    stop();
  endtask
endmodule // bfl_host_model

/* bfl_testbench.sv */
`timescale 1ns/1ns
`include "bfl_defs.vh"
module testbench;
  logic clk_i = 1'b0;
  logic rstn_i;
  logic pwm_i;
  logic pwm_enable_i;
  wire scl, sda, sda_o, sda_oe_o, host_low, rd_valid, boost, curve, lit, busy;
  wire [7:0] rd_data;
  wire [10:0] code;
  wire [19:0] cur;
  wire [11:0] duty;
  wire [3:0] torch, flash;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0000_d2fd;
  logic [7:0] expq[$];
  logic [7:0] rv[5] = '{8'h30, 8'h0d, 8'h07, 8'hff, 8'h3e};
  // pull-up on the shared data line
  assign sda = (sda_oe_o ? sda_o : 1'b1) & !host_low;
  always #10 clk_i = ~clk_i;
  // four clocks per microsecond: short ramps, yet the two sample rates differ
  bfl_backlight_flash_regs #(.CYC_PER_US(4)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .pwm_i(pwm_i), .pwm_enable_i(pwm_enable_i),
    .boost_switch_freq_select_o(boost), .brightness_curve_select_o(curve),
    .backlight_on_o(lit), .ramp_busy_o(busy), .ramp_code_o(code), .led_current_o(cur),
    .pwm_duty_o(duty), .torch_current_level_o(torch), .flash_current_level_o(flash)
  );
  bfl_host_model host (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data)
  );
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] ra, input logic [7:0] e);
    expq.push_back(e);
    host.rd(ra, 1);
  endtask
  int waited = 0;
  task automatic wait_duty(input logic [11:0] lo, input logic [11:0] hi);
    int n;
    for (n = 0; n < 60000 && !(duty >= lo && duty <= hi); n++) host.tick(1);
    waited = n;
    chk(20'(duty >= lo && duty <= hi), 20'h0_0001);
    host.tick(3);
  endtask
  // read results land here in issue order
  always @(posedge clk_i) begin
    if (rd_valid === 1'b1) chk(20'(rd_data), 20'(expq.pop_front()));
  end
  // noisy pwm near one quarter duty, plus the hang guard
  always @(posedge clk_i) begin
    #2;
    pwm_i = (xs() & 32'h0000_0003) == 32'h0000_0000;
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    logic [7:0] v;
    int n;
    rstn_i = 1'b0;
    pwm_enable_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #2 rstn_i = 1'b1;
    host.tick(3);
    foreach (rv[i]) expq.push_back(rv[i]);
    host.rd(8'h02, 5);
    chk(20'(torch), 20'h0_0003);
    chk(20'(flash), 20'h0_000e);
    rdx(8'h10, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'(xs());
      host.wr(`BFL_DEV_ADDR, 8'h06, v);
      host.wr(`BFL_DEV_ADDR, 8'h03, v);
      chk(20'(torch), 20'(v[7:4]));
      chk(20'(flash), 20'(v[3:0]));
      chk(20'(boost), 20'(v[7]));
      rdx(8'h06, v);
      rdx(8'h03, v);
    end
    host.wr(7'h12, 8'h06, 8'h00);
    chk(20'(host.nacks), 20'h0_0003);
    chk(20'(torch), 20'(v[7:4]));
    host.wr(`BFL_DEV_ADDR, 8'h02, 8'hff);
    rdx(8'h02, 8'hf8);
    host.wr(`BFL_DEV_ADDR, 8'h04, 8'hff);
    rdx(8'h04, 8'h07);
    host.wr(`BFL_DEV_ADDR, 8'h03, 8'h05);
    host.wr(`BFL_DEV_ADDR, 8'h02, 8'h30);
    host.wr(`BFL_DEV_ADDR, 8'h04, 8'h00);
    host.wr(`BFL_DEV_ADDR, 8'h05, 8'h00);
    host.tick(3);
    chk({code, lit, cur[7:0]}, 20'h0_0000);
    host.wr(`BFL_DEV_ADDR, 8'h04, 8'h05);
    host.wr(`BFL_DEV_ADDR, 8'h05, 8'h12);
    host.tick(3);
    chk(20'(code), 20'h0_0095);
    chk(cur, 20'h0_025d + 20'h0_00c3 * 20'h0_0095);
    host.wr(`BFL_DEV_ADDR, 8'h02, 8'h20);
    chk(20'(curve), 20'h0_0000);
    host.wr(`BFL_DEV_ADDR, 8'h03, 8'h0d);
    fork
      host.wr(`BFL_DEV_ADDR, 8'h05, 8'h13);
      begin
        for (n = 0; n < 2000 && busy !== 1'b1; n++) host.tick(1);
        // 500 us at four clocks per microsecond
        for (n = 0; n < 4000 && code !== 11'h09d; n++) host.tick(1);
        chk(20'(n >= 1998 && n <= 2002), 20'h0_0001);
      end
    join
    host.tick(2);
    chk(20'(busy), 20'h0_0000);
    host.wr(`BFL_DEV_ADDR, 8'h02, 8'h30);
    host.wr(`BFL_DEV_ADDR, 8'h03, 8'h05);
    pwm_enable_i = 1'b1;
    wait_duty(12'h1b8, 12'h248);
    chk(20'(waited >= 2047 && waited <= 2049), 20'h0_0001);
    chk(20'(code), (20'h0_009d * 20'(duty)) >> 11);
    host.wr(`BFL_DEV_ADDR, 8'h02, 8'h38);
    wait_duty(12'h5b8, 12'h648);
    pwm_enable_i = 1'b0;
    host.tick(3);
    chk(20'(code), 20'h0_009d);
    // slow sampling: 2048 samples, one every four clocks
    host.wr(`BFL_DEV_ADDR, 8'h02, 8'h30);
    host.wr(`BFL_DEV_ADDR, 8'h03, 8'h01);
    pwm_enable_i = 1'b1;
    wait_duty(12'h1b8, 12'h248);
    chk(20'(waited >= 8188 && waited <= 8196), 20'h0_0001);
    pwm_enable_i = 1'b0;
    rstn_i = 1'b0;
    host.tick(2);
    rstn_i = 1'b1;
    host.tick(3);
    rdx(8'h03, 8'h0d);
    host.tick(2);
    final_report();
  end
endmodule // testbench
